// [src/ripcu_cfg.svh]
// constants for the remote i/o port command unit
// included only by the top design file; the package and the counter do not include it
`ifndef RIPCU_CFG_SVH
`define RIPCU_CFG_SVH
`define RIPCU_HDR_CMD 8'h01
`define RIPCU_HDR_RSP 8'h02
`define RIPCU_NAK_A 8'hfb
`define RIPCU_NAK_B 8'hfe
`define RIPCU_NET_ADDR 8'hff
`define RIPCU_DEV_TYPE 8'h5a
`define RIPCU_NPORT 3
`define RIPCU_NCNT 5
`define RIPCU_LOG_MAX 7'h3f
`define RIPCU_NPIN 8'h18
`define RIPCU_CLK_MHZ 100
`define RIPCU_TICK_US 1000
`define RIPCU_C_LDDR 8'h1e
`define RIPCU_C_LDALL 8'h03
`define RIPCU_C_RD0 8'h04
`define RIPCU_C_MR0 8'h08
`define RIPCU_C_PM0 8'h0c
`define RIPCU_C_RDALL 8'h07
`define RIPCU_C_MRALL 8'h0b
`define RIPCU_C_PMALL 8'h0f
`define RIPCU_C_AND 8'h10
`define RIPCU_C_OR 8'h11
`define RIPCU_C_XOR 8'h12
`define RIPCU_C_BSET 8'h14
`define RIPCU_C_BCLR 8'h15
`define RIPCU_C_BTST 8'h16
`define RIPCU_C_BTGL 8'h17
`define RIPCU_C_CCFG 8'h18
`define RIPCU_C_CINC 8'h19
`define RIPCU_C_CRD 8'h1a
`define RIPCU_C_CCLR 8'h1b
`define RIPCU_C_LSTART 8'h1c
`define RIPCU_C_LRD 8'h1d
`define RIPCU_C_TYPE 8'h20
`define RIPCU_C_LAST 8'h21
`define RIPCU_C_ERR 8'h22
`define RIPCU_C_RST 8'h23
`define RIPCU_C_NETRST 8'h24
`define RIPCU_E_STREAM 8'h01
`define RIPCU_E_LRC 8'h02
`define RIPCU_E_CMD 8'h03
`define RIPCU_E_SEP 8'h04
`endif

// [src/ripcu_evcnt.sv]
// one 16-bit event counter with selectable increment source
// assumes ticks are one-cycle pulses on clk_sys
`timescale 1ns/100ps
module ripcu_evcnt #(parameter int W = 16)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire ripcu_pkg::ripcu_src_t src,
   input wire logic tick_tmr,
   input wire logic tick_ext,
   input wire logic tick_host,
   input wire logic clr,
   output logic [W-1:0] count_q,
   output logic evt_q
);
   import ripcu_pkg::*;
   logic hit;

   // only the selected source counts
   always_comb
   begin
      case (src)
         SRC_TIMER: hit = tick_tmr;
         SRC_EXT: hit = tick_ext;
         SRC_HOST: hit = tick_host;
         default: hit = 1'b0;
      endcase
   end

   // up count, wraps at full scale; clear wins
   always_ff @(posedge clk_sys)
   begin
      if (reset || clr)
         count_q <= '0;
      else if (hit)
         count_q <= count_q + 1'b1;
   end

   // event pulse for the data log trigger
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         evt_q <= 1'b0;
      else
         evt_q <= hit && !clr;
   end

   count_up_a: assert property (@(posedge clk_sys) disable iff (reset)
      hit && !clr |=> count_q == $past(count_q) + 1'b1)
      else $error("counter missed an event");
endmodule

// [src/ripcu_pkg.sv]
// types of the remote i/o port command unit
// uses no ripcu_cfg.svh macros, so needs no include path
package ripcu_pkg;
   typedef enum logic [1:0] {SRC_NONE, SRC_TIMER, SRC_EXT, SRC_HOST} ripcu_src_t;
   typedef enum {ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_LRC, ST_EXEC, ST_SEND} ripcu_state_t;
endpackage

// [src/ripcu_top.sv]
// command interpreter of the remote i/o slave: frames, ports, counters, log
// assumes a byte-level serial receiver/transmitter on clk_sys beside it
// Overview of operation
// - masked read passes pins with mask 1, forces mask-0 pins to zero
// - stored masks persist and serve previous-mask reads until replaced
// - every port load answers with the resulting port state
// - and/or/xor host data into one or all ports, drive and return result
// - set, clear, test, toggle one pin chosen by bit number
// - bit commands never change an input pin
// - five 16-bit up counters fed by timer, interrupt or host
// - log selected ports into at most 63 bytes on counter events
// - log read returns the whole log in one response
// - stream errors get no reply at all
// - functional errors reply header, address, error code, check byte
// - code 1e loads three direction registers, no data returned
// - codes 00-02 load one port from one byte, reply one byte
// - code 03 loads all ports, replies three resulting bytes
// - codes 04-06 read one port, reply one byte
// - code 07 reads all ports, replies three bytes
// - codes 08-0a store one mask, reply one masked byte
// - code 0b stores three masks, replies three masked bytes
// - codes 0c-0e reply one byte masked with its stored mask
// - code 0f replies three bytes masked with stored masks
// - host can query device type, last message, error code
// - reset on own reset command and on network reset
// - direction bit 0 is input, 1 is output
// - reads sample all pins, writes touch output pins only
// - commands start with 01, responses with 02
`timescale 1ns/100ps
`include "ripcu_cfg.svh"
module ripcu_top #(parameter int TICK_CYCLES = `RIPCU_TICK_US * `RIPCU_CLK_MHZ)
(
   input wire logic clk_sys,
   input wire logic reset,
   input wire logic [7:0] dev_addr,
   input wire logic rx_valid,
   input wire logic [7:0] rx_byte,
   input wire logic rx_stream_err,
   input wire logic rx_sep_err,
   output logic tx_valid_q,
   output logic [7:0] tx_byte_q,
   input wire logic tx_ready,
   output logic rts_n_q,
   input wire logic cts_n,
   input wire logic ext_int_n,
   input wire logic [2:0][7:0] port_pin_n_i,
   output logic [2:0][7:0] port_pin_n_q,
   output logic [2:0][7:0] port_oe_q
);
   import ripcu_pkg::*;
   ripcu_state_t state_q;
   logic rst, soft_rst_q;
   logic [2:0][7:0] pin_s1_q, pin_s2_q, read_mask_register_q, val, rd;
   logic [7:0] addr_s1_q, addr_s2_q, cmd_q, lrc_q, err_q, rsp_code_q;
   logic [2:0][7:0] dat_q, rsp_q;
   logic [1:0] dcnt_q, dlen;
   logic known, cmd_has_data;
   logic [6:0] rsp_len_q, idx_q, log_cnt_q;
   logic rsp_log_q;
   logic [7:0] log_mem [0:62];
   logic [7:0] tx_lrc_q, cur;
   logic [2:0] int_s_q, cts_s_q;
   logic [31:0] tmr_q;
   logic tick_tmr;
   ripcu_src_t cnt_src_q [`RIPCU_NCNT];
   logic [`RIPCU_NCNT-1:0] host_inc, host_clr, cnt_evt;
   logic [15:0] cnt_val [`RIPCU_NCNT];
   logic [2:0] log_ports_q, log_pend_q;
   logic [2:0] log_one;
   logic [2:0] log_trig_q;
   logic exec, log_start;
   logic [1:0] psel, lp;
   logic [7:0] lres;
   logic [2:0][7:0] lall;
   logic [4:0] bitn;
   logic [2:0] cidx;

   assign rst = reset || soft_rst_q;
   assign exec = state_q == ST_EXEC;

   // pins and strap address cross in through two flops, interrupt and cts through three
   always_ff @(posedge clk_sys)
   begin
      pin_s1_q <= port_pin_n_i;
      pin_s2_q <= pin_s1_q;
      addr_s1_q <= dev_addr;
      addr_s2_q <= addr_s1_q;
      int_s_q <= {int_s_q[1:0], ext_int_n};
      cts_s_q <= {cts_s_q[1:0], cts_n};
   end

   // port views: rd samples every pin, val is the driven/sampled state
   always_comb
   begin
      for (int p = 0; p < `RIPCU_NPORT; p++)
      begin
         rd[p] = ~pin_s2_q[p];
         val[p] = (~port_pin_n_q[p] & port_oe_q[p]) | (rd[p] & ~port_oe_q[p]);
      end
   end

   // command length table; unknown codes are dropped silently
   always_comb
   begin
      known = 1'b1;
      dlen = 2'd0;
      case (cmd_q)
         `RIPCU_C_LDDR, `RIPCU_C_LDALL, `RIPCU_C_MRALL: dlen = 2'd3;
         `RIPCU_C_RDALL, `RIPCU_C_PMALL, `RIPCU_C_TYPE, `RIPCU_C_LAST, `RIPCU_C_ERR,
         `RIPCU_C_RST, `RIPCU_C_NETRST, `RIPCU_C_LRD: dlen = 2'd0;
         `RIPCU_C_AND, `RIPCU_C_OR, `RIPCU_C_XOR, `RIPCU_C_CCFG, `RIPCU_C_LSTART: dlen = 2'd2;
         `RIPCU_C_BSET, `RIPCU_C_BCLR, `RIPCU_C_BTST, `RIPCU_C_BTGL, `RIPCU_C_CINC,
         `RIPCU_C_CRD, `RIPCU_C_CCLR: dlen = 2'd1;
         default:
         begin
            if (cmd_q < `RIPCU_C_LDALL || (cmd_q >= `RIPCU_C_MR0 && cmd_q < `RIPCU_C_MRALL))
               dlen = 2'd1;
            else if (!(cmd_q > `RIPCU_C_LDALL && cmd_q < `RIPCU_C_PMALL))
               known = 1'b0;
         end
      endcase
      cmd_has_data = dlen != 2'd0;
   end

   // frame parser: header, address, code, data, check byte
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         state_q <= ST_IDLE;
         lrc_q <= 8'h00;
         cmd_q <= 8'h00;
         dcnt_q <= 2'd0;
         dat_q <= '0;
         err_q <= 8'h00;
      end
      else if ((rx_stream_err || rx_sep_err) && state_q != ST_EXEC && state_q != ST_SEND)
      begin
         state_q <= ST_IDLE;
         err_q <= rx_stream_err ? `RIPCU_E_STREAM : `RIPCU_E_SEP;
      end
      else
      begin
         case (state_q)
            ST_IDLE:
               if (rx_valid && rx_byte == `RIPCU_HDR_CMD)
               begin
                  lrc_q <= rx_byte;
                  state_q <= ST_ADDR;
               end
            ST_ADDR:
               if (rx_valid)
               begin
                  lrc_q <= lrc_q ^ rx_byte;
                  dat_q[2] <= rx_byte; // address parked until code arrives
                  state_q <= ST_CMD;
               end
            ST_CMD:
               if (rx_valid)
               begin
                  lrc_q <= lrc_q ^ rx_byte;
                  cmd_q <= rx_byte;
                  dcnt_q <= 2'd0;
                  state_q <= ST_DATA;
               end
            ST_DATA:
               if (!known)
               begin
                  state_q <= ST_IDLE;
                  err_q <= `RIPCU_E_CMD;
               end
               else if (dat_q[2] != addr_s2_q && !(dat_q[2] == `RIPCU_NET_ADDR && cmd_q == `RIPCU_C_NETRST))
                  state_q <= ST_IDLE; // not for this unit
               else if (!cmd_has_data)
                  state_q <= ST_LRC;
               else if (rx_valid)
               begin
                  lrc_q <= lrc_q ^ rx_byte;
                  dat_q[dcnt_q] <= rx_byte;
                  dcnt_q <= dcnt_q + 2'd1;
                  if (dcnt_q + 2'd1 == dlen)
                     state_q <= ST_LRC;
               end
            ST_LRC:
               if (rx_valid)
               begin
                  state_q <= (rx_byte == lrc_q) ? ST_EXEC : ST_IDLE;
                  if (rx_byte != lrc_q)
                     err_q <= `RIPCU_E_LRC;
               end
            ST_EXEC:
            begin
               state_q <= (cmd_q == `RIPCU_C_RST || cmd_q == `RIPCU_C_NETRST) ? ST_IDLE : ST_SEND;
               if (cmd_q == `RIPCU_C_ERR)
                  err_q <= 8'h00; // error code cleared once reported
            end
            ST_SEND:
               if (idx_q == rsp_len_q + 7'd4 && !tx_valid_q)
                  state_q <= ST_IDLE;
            default: state_q <= ST_IDLE;
         endcase
      end
   end

   assign psel = cmd_q[1:0];
   assign bitn = dat_q[0][4:0];
   assign cidx = dat_q[0][2:0];
   assign lp = dat_q[0][1:0];

   // logic operation on one port value
   always_comb
   begin
      case (cmd_q)
         `RIPCU_C_AND: lres = val[lp] & dat_q[1];
         `RIPCU_C_OR: lres = val[lp] | dat_q[1];
         default: lres = val[lp] ^ dat_q[1];
      endcase
      // all-ports form, kept out of the clocked process
      for (int p = 0; p < `RIPCU_NPORT; p++)
         lall[p] = (cmd_q == `RIPCU_C_AND) ? val[p] & dat_q[1] :
                   (cmd_q == `RIPCU_C_OR) ? val[p] | dat_q[1] : val[p] ^ dat_q[1];
   end

   // command execution: ports, directions, masks and response buffer
   always_ff @(posedge clk_sys)
   begin
      if (rst)
      begin
         port_pin_n_q <= {3{8'hff}};
         port_oe_q <= '0;
         read_mask_register_q <= {3{8'hff}};
         rsp_q <= '0;
         rsp_len_q <= 7'd0;
         rsp_code_q <= 8'h00;
         rsp_log_q <= 1'b0;
         log_ports_q <= 3'd0;
         log_trig_q <= 3'd0;
         for (int c = 0; c < `RIPCU_NCNT; c++)
            cnt_src_q[c] <= SRC_NONE;
      end
      else if (exec && cmd_q != `RIPCU_C_LAST) // last-message query resends untouched buffer
      begin
         rsp_code_q <= cmd_q;
         rsp_len_q <= 7'd0;
         rsp_log_q <= 1'b0;
         if (cmd_q == `RIPCU_C_LDDR)
            port_oe_q <= dat_q;
         else if (cmd_q < `RIPCU_C_LDALL)
         begin
            port_pin_n_q[psel] <= (port_pin_n_q[psel] & ~port_oe_q[psel]) | (~dat_q[0] & port_oe_q[psel]);
            rsp_q[0] <= (dat_q[0] & port_oe_q[psel]) | (rd[psel] & ~port_oe_q[psel]);
            rsp_len_q <= 7'd1;
         end
         else if (cmd_q == `RIPCU_C_LDALL)
         begin
            for (int p = 0; p < `RIPCU_NPORT; p++)
            begin
               port_pin_n_q[p] <= (port_pin_n_q[p] & ~port_oe_q[p]) | (~dat_q[p] & port_oe_q[p]);
               rsp_q[p] <= (dat_q[p] & port_oe_q[p]) | (rd[p] & ~port_oe_q[p]);
            end
            rsp_len_q <= 7'd3;
         end
         else if (cmd_q < `RIPCU_C_RDALL)
         begin
            rsp_q[0] <= rd[2'(cmd_q - `RIPCU_C_RD0)];
            rsp_len_q <= 7'd1;
         end
         else if (cmd_q == `RIPCU_C_RDALL)
         begin
            rsp_q <= rd;
            rsp_len_q <= 7'd3;
         end
         else if (cmd_q < `RIPCU_C_MRALL)
         begin
            read_mask_register_q[2'(cmd_q - `RIPCU_C_MR0)] <= dat_q[0];
            rsp_q[0] <= rd[2'(cmd_q - `RIPCU_C_MR0)] & dat_q[0];
            rsp_len_q <= 7'd1;
         end
         else if (cmd_q == `RIPCU_C_MRALL)
         begin
            read_mask_register_q <= dat_q;
            rsp_q <= rd & dat_q;
            rsp_len_q <= 7'd3;
         end
         else if (cmd_q < `RIPCU_C_PMALL)
         begin
            rsp_q[0] <= rd[2'(cmd_q - `RIPCU_C_PM0)] & read_mask_register_q[2'(cmd_q - `RIPCU_C_PM0)];
            rsp_len_q <= 7'd1;
         end
         else if (cmd_q == `RIPCU_C_PMALL)
         begin
            rsp_q <= rd & read_mask_register_q;
            rsp_len_q <= 7'd3;
         end
         else if (cmd_q >= `RIPCU_C_AND && cmd_q <= `RIPCU_C_XOR)
         begin
            if (lp == 2'd3)
            begin
               for (int p = 0; p < `RIPCU_NPORT; p++)
               begin
                  port_pin_n_q[p] <= (port_pin_n_q[p] & ~port_oe_q[p]) | (~lall[p] & port_oe_q[p]);
                  rsp_q[p] <= (lall[p] & port_oe_q[p]) | (rd[p] & ~port_oe_q[p]);
               end
               rsp_len_q <= 7'd3;
            end
            else
            begin
               port_pin_n_q[lp] <= (port_pin_n_q[lp] & ~port_oe_q[lp]) | (~lres & port_oe_q[lp]);
               rsp_q[0] <= (lres & port_oe_q[lp]) | (rd[lp] & ~port_oe_q[lp]);
               rsp_len_q <= 7'd1;
            end
         end
         else if (cmd_q >= `RIPCU_C_BSET && cmd_q <= `RIPCU_C_BTGL)
         begin
            if (dat_q[0] >= `RIPCU_NPIN)
               rsp_code_q <= `RIPCU_NAK_B;
            else
            begin
               // input pins keep their level, only output bits move
               if (port_oe_q[bitn[4:3]][bitn[2:0]] && cmd_q != `RIPCU_C_BTST)
                  port_pin_n_q[bitn[4:3]][bitn[2:0]] <= (cmd_q == `RIPCU_C_BSET) ? 1'b0 :
                     (cmd_q == `RIPCU_C_BCLR) ? 1'b1 : ~port_pin_n_q[bitn[4:3]][bitn[2:0]];
               rsp_q[0] <= {7'd0, rd[bitn[4:3]][bitn[2:0]]};
               rsp_len_q <= 7'd1;
            end
         end
         else if (cmd_q >= `RIPCU_C_CCFG && cmd_q <= `RIPCU_C_CCLR)
         begin
            if (cidx >= 3'(`RIPCU_NCNT) || dat_q[0][7:3] != 5'd0)
               rsp_code_q <= `RIPCU_NAK_A;
            else if (cmd_q == `RIPCU_C_CCFG)
               cnt_src_q[cidx] <= ripcu_src_t'(dat_q[1][1:0]);
            else if (cmd_q != `RIPCU_C_CCLR)
            begin
               rsp_q[0] <= cnt_val[cidx][15:8]; // count before this command's own increment
               rsp_q[1] <= cnt_val[cidx][7:0];
               rsp_len_q <= 7'd2;
            end
         end
         else if (cmd_q == `RIPCU_C_LSTART)
         begin
            if (dat_q[1] >= 8'(`RIPCU_NCNT))
               rsp_code_q <= `RIPCU_NAK_A;
            else
            begin
               log_ports_q <= dat_q[0][2:0];
               log_trig_q <= dat_q[1][2:0];
            end
         end
         else if (cmd_q == `RIPCU_C_LRD)
         begin
            rsp_log_q <= 1'b1;
            rsp_len_q <= log_cnt_q;
         end
         else if (cmd_q == `RIPCU_C_TYPE)
         begin
            rsp_q[0] <= `RIPCU_DEV_TYPE;
            rsp_len_q <= 7'd1;
         end
         else if (cmd_q == `RIPCU_C_ERR)
         begin
            rsp_q[0] <= err_q;
            rsp_len_q <= 7'd1;
         end
      end
   end

   // own reset and network reset act one cycle after execution
   always_ff @(posedge clk_sys)
   begin
      if (reset)
         soft_rst_q <= 1'b0;
      else
         soft_rst_q <= exec && (cmd_q == `RIPCU_C_RST || cmd_q == `RIPCU_C_NETRST);
   end

   // timer tick and interrupt edge feed the counters
   always_ff @(posedge clk_sys)
   begin
      if (rst || tmr_q == 32'(TICK_CYCLES - 1))
         tmr_q <= 32'd0;
      else
         tmr_q <= tmr_q + 32'd1;
   end
   assign tick_tmr = tmr_q == 32'(TICK_CYCLES - 1);

   always_comb
   begin
      for (int c = 0; c < `RIPCU_NCNT; c++)
      begin
         host_inc[c] = exec && cmd_q == `RIPCU_C_CINC && cidx == 3'(c) && dat_q[0][7:3] == 5'd0;
         host_clr[c] = exec && cmd_q == `RIPCU_C_CCLR && cidx == 3'(c) && dat_q[0][7:3] == 5'd0;
      end
   end

   for (genvar g = 0; g < `RIPCU_NCNT; g++)
   begin : g_cnt
      ripcu_evcnt #(.W(16)) u_cnt (
         .clk_sys(clk_sys),
         .reset(rst),
         .src(cnt_src_q[g]),
         .tick_tmr(tick_tmr),
         .tick_ext(int_s_q[2] && !int_s_q[1]),
         .tick_host(host_inc[g]),
         .clr(host_clr[g]),
         .count_q(cnt_val[g]),
         .evt_q(cnt_evt[g])
      );
   end

   // log capture: one selected port per cycle, stops at 63 bytes
   assign log_start = exec && cmd_q == `RIPCU_C_LSTART && dat_q[1] < 8'(`RIPCU_NCNT);
   // lowest pending port goes first; a one-hot pick needs no variable part-select
   assign log_one = log_pend_q & (~log_pend_q + 3'd1);
   always_ff @(posedge clk_sys)
   begin
      if (rst || log_start)
      begin
         log_cnt_q <= 7'd0;
         log_pend_q <= 3'd0;
      end
      else if (cnt_evt[log_trig_q] && log_ports_q != 3'd0)
         log_pend_q <= log_ports_q; // a new event restarts the sweep
      else if (log_pend_q != 3'd0)
      begin
         for (int p = `RIPCU_NPORT - 1; p >= 0; p--)
            if (log_one[p])
            begin
               log_pend_q[p] <= 1'b0;
               if (log_cnt_q < `RIPCU_LOG_MAX)
               begin
                  log_mem[log_cnt_q[5:0]] <= rd[p];
                  log_cnt_q <= log_cnt_q + 7'd1;
               end
            end
      end
   end

   // response byte at the current position
   always_comb
   begin
      if (idx_q == 7'd0)
         cur = `RIPCU_HDR_RSP;
      else if (idx_q == 7'd1)
         cur = addr_s2_q;
      else if (idx_q == 7'd2)
         cur = rsp_code_q;
      else if (idx_q == rsp_len_q + 7'd3)
         cur = tx_lrc_q;
      else if (rsp_log_q)
         cur = log_mem[6'(idx_q - 7'd3)];
      else
         cur = rsp_q[2'(idx_q - 7'd3)];
   end

   // transmit side, gated by clear-to-send
   always_ff @(posedge clk_sys)
   begin
      if (rst || exec)
      begin
         idx_q <= 7'd0;
         tx_lrc_q <= 8'h00;
         tx_valid_q <= 1'b0;
         tx_byte_q <= 8'h00;
         rts_n_q <= 1'b1;
      end
      else if (state_q == ST_SEND)
      begin
         rts_n_q <= 1'b0;
         if (idx_q <= rsp_len_q + 7'd3 && !cts_s_q[2] && (!tx_valid_q || tx_ready))
         begin
            tx_valid_q <= 1'b1;
            tx_byte_q <= cur;
            tx_lrc_q <= tx_lrc_q ^ cur;
            idx_q <= idx_q + 7'd1;
         end
         else if (tx_ready)
            tx_valid_q <= 1'b0;
      end
      else
         rts_n_q <= 1'b1;
   end

   mask_read_a: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cmd_q == `RIPCU_C_PMALL |=> rsp_q == ($past(rd) & $past(read_mask_register_q)))
      else $error("masked read wrong");
   in_pin_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cmd_q >= `RIPCU_C_BSET && cmd_q <= `RIPCU_C_BTGL |=>
      ((port_pin_n_q ^ $past(port_pin_n_q)) & ~port_oe_q) == '0)
      else $error("bit command moved an input pin");
   rsp_header_a: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_SEND && $rose(tx_valid_q) && idx_q == 7'd1 |-> tx_byte_q == `RIPCU_HDR_RSP)
      else $error("response header wrong");
   no_reply_a: assert property (@(posedge clk_sys) disable iff (rst)
      state_q == ST_LRC && rx_valid && rx_byte != lrc_q |=> state_q == ST_IDLE)
      else $error("bad check byte not dropped");
   ddr_load_a: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cmd_q == `RIPCU_C_LDDR |=> port_oe_q == $past(dat_q) && rsp_len_q == 7'd0)
      else $error("direction load wrong");
   mask_keep_a: assert property (@(posedge clk_sys) disable iff (rst)
      !rst && !(exec && (cmd_q == `RIPCU_C_MRALL || (cmd_q >= `RIPCU_C_MR0 && cmd_q < `RIPCU_C_MRALL))) |=>
      read_mask_register_q == $past(read_mask_register_q))
      else $error("mask changed without mask command");
   log_limit_a: assert property (@(posedge clk_sys) disable iff (rst)
      log_cnt_q <= `RIPCU_LOG_MAX)
      else $error("log overflow");
   nak_bit_a: assert property (@(posedge clk_sys) disable iff (rst)
      exec && cmd_q == `RIPCU_C_BSET && dat_q[0] >= `RIPCU_NPIN |=> rsp_code_q == `RIPCU_NAK_B)
      else $error("missing error reply");
   soft_reset_a: assert property (@(posedge clk_sys) disable iff (reset)
      exec && cmd_q == `RIPCU_C_RST |=> soft_rst_q ##1 state_q == ST_IDLE && port_oe_q == '0)
      else $error("reset command ignored");
endmodule

// [verif/ripcu_host.sv]
// host model: frames commands onto the byte link, collects the reply
// assumes the unit on clk_sys; cts follows rts as a willing modem would
`timescale 1ns/100ps
module ripcu_host
(
   input wire logic clk_sys,
   output logic rx_valid,
   output logic [7:0] rx_byte,
   output logic rx_stream_err,
   output logic rx_sep_err,
   input wire logic tx_valid_q,
   input wire logic [7:0] tx_byte_q,
   output logic tx_ready,
   input wire logic rts_n_q,
   output logic cts_n
);
   logic [7:0] rsp[$];
   logic slow = 1'b0;
   initial {rx_valid, rx_stream_err, rx_sep_err, tx_ready, cts_n, rx_byte} = 13'h0100;
   // slow mode drops tx_ready on every other cycle
   always @(posedge clk_sys)
   begin
      if (tx_valid_q && tx_ready)
         rsp.push_back(tx_byte_q);
      tx_ready <= !slow || !tx_ready;
      cts_n <= rts_n_q;
   end
   // k: 1 bad check byte, 2 separation fault, 3 stream fault instead of check byte
   task automatic xfer(input logic [7:0] f[$], input logic [1:0] k, output logic to);
      logic [7:0] x;
      int n;
      x = 8'h01;
      foreach (f[i]) x ^= f[i];
      f.push_front(8'h01);
      f.push_back(x ^ {7'h0, k == 2'h1});
      rsp = {};
      foreach (f[i])
      begin
         @(posedge clk_sys);
         n = k[1] && i == f.size() - 1;
         rx_valid <= !n;
         rx_stream_err <= n && k[0];
         rx_sep_err <= n && !k[0];
         rx_byte <= f[i];
         @(posedge clk_sys);
         {rx_valid, rx_stream_err, rx_sep_err} <= 3'h0;
         rx_byte <= ~f[i]; // released line must not look like the old byte
      end
      for (n = 0; n < 40 && rts_n_q; n++) @(posedge clk_sys);
      for (n = 0; n < 300 && !rts_n_q; n++) @(posedge clk_sys);
      to = n == 300;
   endtask
endmodule

// [verif/testbench.sv]
// self-checking bench of the port command unit: row table, then hand cases
// assumes the host model beside it; pins show drive or outside gear
`timescale 1ns/100ps
module testbench;
   logic clk_sys, reset, rx_valid, rx_stream_err, rx_sep_err, tx_valid_q, tx_ready, rts_n_q, cts_n, to;
   logic ext_int_n = 1'b1;
   logic [7:0] rx_byte, tx_byte_q, dev_addr = 8'h42;
   logic [2:0][7:0] port_pin_n_i, port_pin_n_q, port_oe_q, ext = 24'h3ca500;
   int failures = 0;
   int cmp_count = 0;
   // reply code, command, data and reply counts, three data bytes, three reply bytes
   logic [71:0] rows [27] = '{
      72'h1e1e_30_ff0f00_000000, 72'h0000_11_550000_550000, 72'h0101_11_ff0000_af0000,
      72'h0303_33_112233_11a23c, 72'h0505_01_000000_a20000, 72'h0707_03_000000_11a23c,
      72'h0909_11_0f0000_020000, 72'h0b0b_33_fff00f_11a00c, 72'h0d0d_01_000000_a00000,
      72'h0f0f_03_000000_11a00c, 72'h1010_21_000f00_010000, 72'h1212_23_03ff00_fead3c,
      72'h1414_11_000000_000000, 72'h1616_11_000000_010000, 72'h1717_11_140000_010000,
      72'h1616_11_140000_010000, 72'hfe14_10_180000_000000, 72'h1818_20_000300_000000,
      72'h1c1c_20_010000_000000, 72'h1919_12_000000_000000, 72'h1a1a_12_000000_000100,
      72'h1d1d_01_000000_ff0000, 72'hfb1a_10_050000_000000, 72'h2020_01_000000_5a0000, 72'h2021_01_000000_5a0000,
      72'h1515_11_000000_010000, 72'h1111_21_01f000_ad0000};
   // output pins follow the drive, inputs follow the outside gear
   assign port_pin_n_i = port_oe_q & port_pin_n_q | ~port_oe_q & ~ext;
   ripcu_top #(.TICK_CYCLES(20)) i_ripcu_top (.*);
   ripcu_host i_ripcu_host (.*);
   // clock
   initial
   begin
      clk_sys = 1'b0;
      forever #5 clk_sys = ~clk_sys;
   end
   task automatic chk(input logic [23:0] s, input logic [23:0] e);
      cmp_count++;
      if (s !== e)
      begin
         failures++;
         $display("unexpected at %0t: saw %h want %h", $time, s, e);
      end
   endtask
   task automatic end_sim();
      $display("compares %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // one frame; a faulted frame must stay unanswered
   task automatic run(input logic [71:0] r, input logic [1:0] k);
      logic [7:0] f[$];
      logic [7:0] e[$];
      logic [7:0] x;
      f = {dev_addr, r[63:56]};
      e = {8'h02, dev_addr, r[71:64]};
      for (int i = 0; i < r[55:52]; i++) f.push_back(r[47 - 8 * i -: 8]);
      for (int i = 0; i < r[51:48]; i++) e.push_back(r[23 - 8 * i -: 8]);
      x = 8'h00;
      foreach (e[i]) x ^= e[i];
      e.push_back(x);
      if (k != 2'h0)
         e = {};
      i_ripcu_host.xfer(f, k, to);
      chk(to, 24'h0);
      if (to)
         end_sim();
      chk(24'(i_ripcu_host.rsp.size()), 24'(e.size()));
      foreach (e[i]) chk(i_ripcu_host.rsp[i], e[i]);
      $display("test %h done", r[63:56]);
   endtask
   // main sequence
   initial
   begin
      reset = 1'b1;
      repeat (4) @(posedge clk_sys);
      reset <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk(port_oe_q, 24'h0);
      chk(port_pin_n_q, '1);
      chk({rts_n_q, tx_valid_q}, 24'h2);
      foreach (rows[i])
      begin
         i_ripcu_host.slow = i > 11;
         run(rows[i], 2'h0);
      end
      run(72'h1818_20_010200_000000, 2'h0);
      repeat (3)
      begin
         ext_int_n <= 1'b0;
         repeat (4) @(posedge clk_sys);
         ext_int_n <= 1'b1;
         repeat (4) @(posedge clk_sys);
      end
      run(72'h1a1a_12_010000_000300, 2'h0);
      run(72'h0707_03_000000_000000, 2'h1);
      run(72'h0707_03_000000_000000, 2'h3);
      i_ripcu_host.xfer({dev_addr, 8'h13}, 2'h0, to);
      chk(24'(i_ripcu_host.rsp.size()), 24'h0);
      run(72'h0707_03_000000_000000, 2'h2);
      run(72'h2222_01_000000_040000, 2'h0);
      run(72'h2222_01_000000_000000, 2'h0);
      i_ripcu_host.xfer({8'h43, 8'h07}, 2'h0, to);
      chk(24'(i_ripcu_host.rsp.size()), 24'h0);
      i_ripcu_host.xfer({dev_addr, 8'h23}, 2'h0, to);
      chk(24'(i_ripcu_host.rsp.size()), 24'h0);
      chk(port_oe_q, 24'h0);
      run(rows[0], 2'h0);
      i_ripcu_host.xfer({8'hff, 8'h24}, 2'h0, to);
      chk(24'(i_ripcu_host.rsp.size()), 24'h0);
      chk(port_oe_q, 24'h0);
      $display("hand cases done");
      end_sim();
   end
endmodule
